//--- src/fpu_ctrl_pkg.sv
// constants for the floating-point rounding and exception control block
// assumes a single clock domain and an instruction issue port from the cpu core
//
// Overview of operation
// - cpu exchanges 32-bit values with the unit only through the transfer word; the code also loads and stores the status register directly.
// - combined operations round once at the end; add, subtract, multiply round alone.
// - rounding select 00 is round to nearest, 01 is round toward zero.
// - nearest rounding picks closest value; ties go to even least significant bit.
// - nearest rounding at or past 2^Emax(2-2^-P) gives same-signed infinity.
// - toward-zero drops bits below round bit; overflow saturates to largest magnitude.
// - fpu disable set makes any fp instruction illegal; slot illegal in delay slot.
// - six sources detected: error, invalid, zero divide, overflow, underflow, inexact.
// - cause has six bits; flag and enable have five, error cannot be masked.
// - occurring source sets cause and flag; absent source clears cause only.
// - error always traps; invalid traps if enabled and transform or invalid.
// - overflow, underflow, inexact trap if enabled and possible; zero divide if actual.
// - all fp traps share one exception event; software reads status register.
// - a taken trap leaves destination unchanged; empty cause means no real source.
// - untrapped invalid gives quiet nan; zero divide gives signed infinity.
// - untrapped overflow gives signed largest normal in toward-zero, infinity otherwise.
// - untrapped underflow gives signed denormal or zero, or zero when flushing.
// - inner product and transform always set inexact cause and flag.
// - transform takes invalid trap whenever invalid enable is set.
// - geometric ops may drop small partial products; 24 or 23 significant digits.
// - status load takes 4 cycles; bank toggle inverts bank select in one.
// - pair select 1 makes moves transfer two words; size toggle inverts it.
// - flag bits stay set until software writes zero; hardware never clears them.
package fpu_ctrl_pkg;
    localparam int         WORD_W        = 32;
    localparam logic [31:0] FPSC_RESET   = 32'h0004_0001;
    localparam int         ROUND_LSB     = 0;
    localparam int         FLAG_LSB      = 2;
    localparam int         EN_LSB        = 7;
    localparam int         CAUSE_LSB     = 12;
    localparam int         FLUSH_BIT     = 18;
    localparam int         PR_BIT        = 19;
    localparam int         PAIR_BIT      = 20;
    localparam int         BANK_BIT      = 21;
    localparam logic [31:0] FPSC_WMASK   = 32'h003f_ffff;
    localparam logic [1:0] ROUND_NEAREST = 2'h0;
    localparam logic [1:0] ROUND_ZERO    = 2'h1;
    // exception bit order in a six-bit vector: e v z o u i (5..0)
    localparam int         X_I = 0;
    localparam int         X_U = 1;
    localparam int         X_O = 2;
    localparam int         X_Z = 3;
    localparam int         X_V = 4;
    localparam int         X_E = 5;
    localparam int         SP_EMAX       = 127;
    localparam int         SP_P          = 24;
    localparam int         SP_FRAC_W     = 23;
    localparam logic [30:0] SP_MAXMAG    = 31'h7f7f_ffff;
    localparam logic [30:0] SP_INFMAG    = 31'h7f80_0000;
    localparam logic [31:0] SP_QNAN      = 32'h7fbf_ffff;
    localparam int         FPSC_LOAD_CYC = 4;
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MAC, OP_INNER,
        OP_XFORM, OP_LOAD_XFER, OP_STORE_XFER, OP_LOAD_FPSC, OP_STORE_FPSC,
        OP_BANK_TOGGLE, OP_SIZE_TOGGLE, OP_MOVE
    } op_type;
endpackage : fpu_ctrl_pkg

//--- src/fpu_round_exception_ctrl.sv
// fp control: status register, exception cause/flag/trap and defaults
// assumes one issue per cycle from the cpu core and a separate arithmetic datapath
`timescale 1ns/10ps
`default_nettype none
module fpu_round_exception_ctrl
    import fpu_ctrl_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    // instruction issue
    input  wire logic        issue_in,
    input  wire op_type      op_in,
    input  wire logic        delay_slot_in,
    input  wire logic        fpu_disable_bit_in,
    input  wire logic [31:0] cpu_data_in,
    // unrounded result and detected conditions from the datapath
    input  wire logic        res_sign_in,
    input  wire logic [9:0]  res_exp_in,
    input  wire logic [23:0] res_mant_in,
    input  wire logic        res_round_in,
    input  wire logic        res_sticky_in,
    input  wire logic        denormal_in_in,
    input  wire logic        invalid_in,
    input  wire logic        zero_divisor_in,
    input  wire logic        may_overflow_in,
    input  wire logic        may_underflow_in,
    input  wire logic        may_inexact_in,
    // answers
    output logic             busy_out,
    output logic [31:0]      cpu_data_out,
    output logic             result_valid_out,
    output logic [31:0]      result_out,
    output logic             dest_write_out,
    output logic             fpu_exception_out,
    output logic             illegal_out,
    output logic             slot_illegal_out,
    output logic             rounding_select_out,
    output logic             denormal_flush_select_out,
    output logic             transfer_pair_select_out,
    output logic             register_bank_select_out
);
    // ============================================================
    // helpers
    // ============================================================
    function automatic logic is_arith(input op_type op);
        return op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MAC, OP_INNER, OP_XFORM};
    endfunction : is_arith

    function automatic logic is_geometric(input op_type op);
        return op inside {OP_INNER, OP_XFORM};
    endfunction : is_geometric

    typedef enum logic [1:0] {S_IDLE, S_LOAD_WAIT} load_state_type;

    logic [31:0]     fp_status_control;
    logic [31:0]     fpu_cpu_transfer_word;
    load_state_type  load_state;
    logic [2:0]      load_cnt;
    logic [31:0]     load_data;
    logic            accept;
    logic            fp_op;
    logic [5:0]      src;
    logic [5:0]      trap_vec;
    logic            trap;
    logic [31:0]     rnd_result;
    logic            rnd_ovf;
    logic            rnd_unf;
    logic            rnd_inx;
    logic [31:0]     default_result;
    logic [4:0]      enables;

    assign enables = fp_status_control[EN_LSB +: 5];
    assign accept  = clk_en_in & issue_in & (load_state == S_IDLE);
    assign fp_op   = op_in != OP_NONE;
    assign busy_out = load_state != S_IDLE;

    // ============================================================
    // rounding: one stage per instruction, so fused ops round once
    // ============================================================
    fpu_round_unit u_round (
        .sign_in                  (res_sign_in),
        .exp_in                   (res_exp_in),
        .mant_in                  (res_mant_in),
        .round_bit_in             (res_round_in),
        .sticky_in                (res_sticky_in),
        .rounding_select_in       (fp_status_control[ROUND_LSB +: 2]),
        .denormal_flush_select_in (fp_status_control[FLUSH_BIT]),
        .result_out               (rnd_result),
        .overflow_out             (rnd_ovf),
        .underflow_out            (rnd_unf),
        .inexact_out              (rnd_inx)
    );

    // ============================================================
    // exception detection and trap decision
    // ============================================================
    always_comb begin
        src = 6'h00;
        if (is_arith(op_in)) begin
            src[X_E] = denormal_in_in & ~fp_status_control[FLUSH_BIT];
            src[X_V] = invalid_in;
            src[X_Z] = (op_in == OP_DIV) & zero_divisor_in;
            src[X_O] = rnd_ovf & ~invalid_in & ~src[X_Z];
            src[X_U] = rnd_unf & ~invalid_in & ~src[X_Z];
            src[X_I] = (rnd_inx & ~invalid_in & ~src[X_Z]) | is_geometric(op_in);
        end
        trap_vec        = 6'h00;
        trap_vec[X_E]   = src[X_E];
        trap_vec[X_V]   = enables[X_V] & ((op_in == OP_XFORM) | src[X_V]);
        trap_vec[X_Z]   = enables[X_Z] & src[X_Z];
        trap_vec[X_O]   = enables[X_O] & may_overflow_in;
        trap_vec[X_U]   = enables[X_U] & may_underflow_in;
        trap_vec[X_I]   = enables[X_I] & (may_inexact_in | is_geometric(op_in));
        trap = is_arith(op_in) & (|trap_vec);
    end

    // untrapped results
    always_comb begin
        default_result = rnd_result;
        if (src[X_V]) begin
            default_result = SP_QNAN;
        end else if (src[X_Z]) begin
            default_result = {res_sign_in, SP_INFMAG};
        end
        // overflow and underflow defaults come from the rounding stage
    end

    // ============================================================
    // status/control register
    // ============================================================
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fp_status_control <= FPSC_RESET;
        end else if (clk_en_in) begin
            if (load_state == S_LOAD_WAIT && load_cnt == 3'h0) begin
                fp_status_control <= load_data & FPSC_WMASK;
            end else if (accept && !fpu_disable_bit_in) begin
                case (op_in)
                    OP_BANK_TOGGLE: begin
                        fp_status_control[BANK_BIT] <= ~fp_status_control[BANK_BIT];
                    end
                    OP_SIZE_TOGGLE: begin
                        fp_status_control[PAIR_BIT] <= ~fp_status_control[PAIR_BIT];
                    end
                    default: begin
                        if (is_arith(op_in)) begin
                            fp_status_control[CAUSE_LSB +: 6] <= src;
                            // flags only ever gain bits here
                            fp_status_control[FLAG_LSB +: 5] <=
                                fp_status_control[FLAG_LSB +: 5] | src[4:0];
                        end
                    end
                endcase
            end
        end
    end

    // status load holds the unit for a few cycles before it lands
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            load_state <= S_IDLE;
            load_cnt   <= 3'h0;
            load_data  <= 32'h0;
        end else if (clk_en_in) begin
            case (load_state)
                S_IDLE: begin
                    if (accept && !fpu_disable_bit_in && op_in == OP_LOAD_FPSC) begin
                        load_state <= S_LOAD_WAIT;
                        load_cnt   <= 3'(FPSC_LOAD_CYC - 2);
                        load_data  <= cpu_data_in;
                    end
                end
                S_LOAD_WAIT: begin
                    if (load_cnt == 3'h0) begin
                        load_state <= S_IDLE;
                    end else begin
                        load_cnt <= load_cnt - 3'h1;
                    end
                end
                default: load_state <= S_IDLE;
            endcase
        end
    end

    // ============================================================
    // transfer word and cpu read data
    // ============================================================
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fpu_cpu_transfer_word <= 32'h0;
        end else if (clk_en_in && accept && !fpu_disable_bit_in
                     && op_in == OP_LOAD_XFER) begin
            fpu_cpu_transfer_word <= cpu_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cpu_data_out <= 32'h0;
        end else if (clk_en_in && accept && !fpu_disable_bit_in) begin
            if (op_in == OP_STORE_XFER) begin
                cpu_data_out <= fpu_cpu_transfer_word;
            end else if (op_in == OP_STORE_FPSC) begin
                cpu_data_out <= fp_status_control;
            end
        end
    end

    // ============================================================
    // per-instruction answers
    // ============================================================
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            result_valid_out  <= 1'b0;
            result_out        <= 32'h0;
            dest_write_out    <= 1'b0;
            fpu_exception_out <= 1'b0;
            illegal_out       <= 1'b0;
            slot_illegal_out  <= 1'b0;
        end else if (clk_en_in) begin
            result_valid_out  <= 1'b0;
            dest_write_out    <= 1'b0;
            fpu_exception_out <= 1'b0;
            illegal_out       <= 1'b0;
            slot_illegal_out  <= 1'b0;
            if (accept && fp_op) begin
                if (fpu_disable_bit_in) begin
                    illegal_out      <= ~delay_slot_in;
                    slot_illegal_out <= delay_slot_in;
                end else if (is_arith(op_in)) begin
                    result_valid_out  <= 1'b1;
                    result_out        <= default_result;
                    fpu_exception_out <= trap;
                    dest_write_out    <= ~trap;
                end
            end
        end
    end

    // geometric ops accept datapath error within the 24/23-digit bound
    assign rounding_select_out       = fp_status_control[ROUND_LSB];
    assign denormal_flush_select_out = fp_status_control[FLUSH_BIT];
    assign transfer_pair_select_out  = fp_status_control[PAIR_BIT];
    assign register_bank_select_out  = fp_status_control[BANK_BIT];

    // ============================================================
    // checks
    // ============================================================
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_disabled_issue;
        accept && fp_op && fpu_disable_bit_in;
    endsequence
    sequence s_load_issue;
        accept && !fpu_disable_bit_in && op_in == OP_LOAD_FPSC;
    endsequence

    a_disable_illegal: assert property (
        s_disabled_issue |=> (illegal_out != slot_illegal_out) && !result_valid_out)
        else $error("disabled fp instruction not reported illegal");
    a_trap_no_write: assert property (
        fpu_exception_out |-> !dest_write_out && result_valid_out)
        else $error("trap wrote the destination");
    a_flag_sticky: assert property (
        clk_en_in && !(load_state == S_LOAD_WAIT && load_cnt == 3'h0)
        |=> (fp_status_control[FLAG_LSB +: 5] & $past(fp_status_control[FLAG_LSB +: 5]))
            == $past(fp_status_control[FLAG_LSB +: 5]))
        else $error("flag bit cleared by hardware");
    a_geom_inexact: assert property (
        accept && !fpu_disable_bit_in && is_geometric(op_in)
        |=> fp_status_control[CAUSE_LSB + X_I] && fp_status_control[FLAG_LSB + X_I])
        else $error("geometric op missed inexact");
    a_error_traps: assert property (
        accept && !fpu_disable_bit_in && is_arith(op_in) && src[X_E] |=> fpu_exception_out)
        else $error("error source did not trap");
    a_xform_invalid: assert property (
        accept && !fpu_disable_bit_in && op_in == OP_XFORM && enables[X_V]
        |=> fpu_exception_out)
        else $error("transform did not take invalid trap");
    a_load_latency: assert property (
        s_load_issue |=> busy_out [*3] ##1 !busy_out)
        else $error("status load latency wrong");
    a_bank_toggle: assert property (
        accept && !fpu_disable_bit_in && op_in == OP_BANK_TOGGLE
        |=> register_bank_select_out != $past(register_bank_select_out))
        else $error("bank select not inverted");
    a_cause_clear: assert property (
        accept && !fpu_disable_bit_in && is_arith(op_in)
        |=> fp_status_control[CAUSE_LSB +: 6] == $past(src))
        else $error("cause field not replaced");
endmodule : fpu_round_exception_ctrl
`default_nettype wire

//--- src/fpu_round_unit.sv
// single-precision rounding stage: one rounding of an unrounded significand
// assumes a normalised 24-bit significand plus guard/sticky from the datapath
`timescale 1ns/10ps
`default_nettype none
module fpu_round_unit
    import fpu_ctrl_pkg::*;
(
    input  wire logic        sign_in,
    input  wire logic [9:0]  exp_in,
    input  wire logic [23:0] mant_in,
    input  wire logic        round_bit_in,
    input  wire logic        sticky_in,
    input  wire logic [1:0]  rounding_select_in,
    input  wire logic        denormal_flush_select_in,
    output logic [31:0]      result_out,
    output logic             overflow_out,
    output logic             underflow_out,
    output logic             inexact_out
);
    logic        inc;
    logic [24:0] sum;
    logic [9:0]  exp_adj;
    logic [22:0] frac;
    always_comb begin
        inc = 1'b0;
        if (rounding_select_in == ROUND_NEAREST) begin
            // ties go to the even significand
            inc = round_bit_in & (sticky_in | mant_in[0]);
        end
        // toward zero never increments: lower bits are simply dropped
        sum     = {1'b0, mant_in} + {24'h000000, inc};
        exp_adj = sum[24] ? exp_in + 10'h001 : exp_in;
        frac    = sum[24] ? sum[23:1] : sum[22:0];
        inexact_out   = round_bit_in | sticky_in;
        overflow_out  = 1'b0;
        underflow_out = 1'b0;
        result_out    = {sign_in, exp_adj[7:0], frac};
        if (!exp_adj[9] && exp_adj >= 10'(2 * SP_EMAX + 1)) begin
            overflow_out = 1'b1;
            inexact_out  = 1'b1;
            if (rounding_select_in == ROUND_NEAREST) begin
                result_out = {sign_in, SP_INFMAG};
            end else begin
                result_out = {sign_in, SP_MAXMAG};
            end
        end else if (exp_adj[9] || exp_adj == 10'h000) begin
            underflow_out = 1'b1;
            inexact_out   = 1'b1;
            // flushing gives signed zero; else the datapath denormal is kept coarsely
            result_out = denormal_flush_select_in ? {sign_in, 31'h0}
                                                  : {sign_in, 8'h00, frac};
        end
    end
endmodule : fpu_round_unit
`default_nettype wire

//--- tb/cpu_issue_model.sv
// cpu core model: issues one fp instruction at a time to the control block
// assumes the bench calls send from its main thread; inputs move at falling edges
`timescale 1ns/10ps
`default_nettype none
module cpu_issue_model
    import fpu_ctrl_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        busy_in,
    output logic             issue_out,
    output var op_type       op_out,
    output logic             delay_slot_out,
    output logic             fpu_disable_out,
    output logic [31:0]      cpu_data_out
);
    initial begin
        issue_out = 1'h0;
        op_out = OP_NONE;
        delay_slot_out = 1'h0;
        fpu_disable_out = 1'h0;
        cpu_data_out = 32'h0;
    end

    // =====================================================================
    // issue
    // waits out a status load first: an issue during busy is dropped silently
    task automatic send(input op_type op, input logic [31:0] d,
                        input logic ds, input logic fd);
        @(negedge clock_in);
        while (busy_in !== 1'h0)
            @(negedge clock_in);
        issue_out = 1'h1;
        op_out = op;
        delay_slot_out = ds;
        fpu_disable_out = fd;
        cpu_data_out = d;
        @(negedge clock_in);
        issue_out = 1'h0;
        op_out = OP_NONE;
        delay_slot_out = 1'h0;
        fpu_disable_out = 1'h0;
        // released data is not left looking valid
        cpu_data_out = ~d;
    endtask : send
endmodule : cpu_issue_model
`default_nettype wire

//--- tb/fpu_round_exception_ctrl_tb.sv
// bench for the fp rounding and exception control block
// assumes the cpu model issues; the bench plays the arithmetic datapath
`timescale 1ns/10ps
`default_nettype none
module fpu_round_exception_ctrl_tb
    import fpu_ctrl_pkg::*;
;
    logic        clock_in, sys_rst_in, clk_en_in, issue_in, delay_slot_in;
    logic        fpu_disable_bit_in, res_sign_in, res_round_in, res_sticky_in;
    op_type      op_in;
    logic [31:0] cpu_data_in, cpu_data_out, result_out, sr;
    logic [9:0]  res_exp_in;
    logic [23:0] res_mant_in;
    logic        denormal_in_in, invalid_in, zero_divisor_in;
    logic        may_overflow_in, may_underflow_in, may_inexact_in;
    logic        busy_out, result_valid_out, dest_write_out, fpu_exception_out;
    logic        illegal_out, slot_illegal_out, rounding_select_out;
    logic        denormal_flush_select_out, transfer_pair_select_out;
    logic        register_bank_select_out;
    int          num_errors, n_compared;

    fpu_round_exception_ctrl u_fpu_round_exception_ctrl (
        .clock_in, .sys_rst_in, .clk_en_in, .issue_in, .op_in, .delay_slot_in,
        .fpu_disable_bit_in, .cpu_data_in, .res_sign_in, .res_exp_in,
        .res_mant_in, .res_round_in, .res_sticky_in, .denormal_in_in,
        .invalid_in, .zero_divisor_in, .may_overflow_in, .may_underflow_in,
        .may_inexact_in, .busy_out, .cpu_data_out, .result_valid_out,
        .result_out, .dest_write_out, .fpu_exception_out, .illegal_out,
        .slot_illegal_out, .rounding_select_out, .denormal_flush_select_out,
        .transfer_pair_select_out, .register_bank_select_out);

    cpu_issue_model u_cpu_issue_model (
        .clock_in(clock_in), .busy_in(busy_out), .issue_out(issue_in),
        .op_out(op_in), .delay_slot_out(delay_slot_in),
        .fpu_disable_out(fpu_disable_bit_in), .cpu_data_out(cpu_data_in));

    // =====================================================================
    // helpers
    function automatic logic [31:0] pk2(input logic a, input logic b);
        return {30'h0, a, b};
    endfunction : pk2

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
            num_errors++;
        end
    endtask : chk

    task automatic op1(input op_type o, input logic [31:0] d);
        u_cpu_issue_model.send(o, d, 1'h0, 1'h0);
    endtask : op1

    task automatic rd(output logic [31:0] v);
        op1(OP_STORE_FPSC, 32'h0);
        v = cpu_data_out;
    endtask : rd

    // datapath conditions c: denormal, invalid, zero divisor, may o/u/i
    task automatic dp(input logic sg, input logic [9:0] ex, input logic [23:0] mn,
                      input logic rb, input logic sb, input logic [5:0] c);
        res_sign_in = sg;
        res_exp_in = ex;
        res_mant_in = mn;
        res_round_in = rb;
        res_sticky_in = sb;
        {denormal_in_in, invalid_in, zero_divisor_in} = c[5:3];
        {may_overflow_in, may_underflow_in, may_inexact_in} = c[2:0];
    endtask : dp

    task automatic rnd(input logic [1:0] rs, input logic sg, input logic [9:0] ex,
                       input logic [23:0] mn, input logic rb, input logic sb,
                       input logic [31:0] want);
        op1(OP_LOAD_FPSC, {30'h0, rs});
        dp(sg, ex, mn, rb, sb, {3'h0, ex > 10'h0fd, 1'h0, rb | sb});
        op1(OP_ADD, 32'h0);
        chk("rounded", want, result_out);
    endtask : rnd

    // =====================================================================
    // scenarios
    task automatic t_regs;
        rd(sr);
        chk("status_reset", FPSC_RESET, sr);
        chk("rm_dn", 32'h3, pk2(rounding_select_out, denormal_flush_select_out));
        u_cpu_issue_model.send(OP_LOAD_FPSC, 32'hfff0_0000, 1'h0, 1'h0);
        for (int i = 1; i <= 4; i++) begin
            chk("busy", pk2(1'h0, i < 4), pk2(1'h0, busy_out));
            @(negedge clock_in);
        end
        rd(sr);
        chk("loaded", 32'h0030_0000, sr);
        op1(OP_BANK_TOGGLE, 32'h0);
        chk("bank", 32'h0, pk2(1'h0, register_bank_select_out));
        op1(OP_SIZE_TOGGLE, 32'h0);
        chk("pair", 32'h0, pk2(1'h0, transfer_pair_select_out));
        op1(OP_SIZE_TOGGLE, 32'h0);
        chk("pair", 32'h1, pk2(1'h0, transfer_pair_select_out));
        op1(OP_LOAD_XFER, 32'h5a3c_96e1);
        op1(OP_STORE_XFER, 32'h0);
        chk("xfer", 32'h5a3c_96e1, cpu_data_out);
    endtask : t_regs

    task automatic t_illegal;
        op1(OP_LOAD_FPSC, 32'h0);
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h10);
        for (int k = 0; k < 2; k++) begin
            u_cpu_issue_model.send(OP_ADD, 32'h0, k[0], 1'h1);
            chk("illegal", pk2(k == 0, k == 1), pk2(illegal_out, slot_illegal_out));
            chk("no_result", 32'h0, pk2(result_valid_out, dest_write_out));
        end
        rd(sr);
        chk("unchanged", 32'h0, sr);
    endtask : t_illegal

    task automatic t_round;
        rnd(ROUND_NEAREST, 1'h0, 10'h07f, 24'h800001, 1'h1, 1'h0, 32'h3f80_0002);
        rnd(ROUND_NEAREST, 1'h0, 10'h07f, 24'h800000, 1'h1, 1'h0, 32'h3f80_0000);
        rnd(ROUND_NEAREST, 1'h1, 10'h07f, 24'h800000, 1'h1, 1'h1, 32'hbf80_0001);
        rnd(ROUND_ZERO, 1'h0, 10'h07f, 24'h800001, 1'h1, 1'h1, 32'h3f80_0001);
        rnd(ROUND_NEAREST, 1'h0, 10'h0fe, 24'hffffff, 1'h1, 1'h0, 32'h7f80_0000);
        rnd(ROUND_NEAREST, 1'h0, 10'h0fe, 24'hffffff, 1'h0, 1'h1, 32'h7f7f_ffff);
        rnd(ROUND_NEAREST, 1'h1, 10'h0ff, 24'h800000, 1'h0, 1'h0, 32'hff80_0000);
        rnd(ROUND_ZERO, 1'h1, 10'h0ff, 24'h800000, 1'h0, 1'h0, 32'hff7f_ffff);
        rnd(ROUND_NEAREST, 1'h1, 10'h000, 24'h800001, 1'h0, 1'h0, 32'h8000_0001);
        op1(OP_LOAD_FPSC, 32'h0004_0000);
        op1(OP_ADD, 32'h0);
        chk("flushed", 32'h8000_0000, result_out);
    endtask : t_round

    task automatic t_except;
        op1(OP_LOAD_FPSC, 32'h0);
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h10);
        op1(OP_ADD, 32'h0);
        chk("qnan", SP_QNAN, result_out);
        chk("written", 32'h1, pk2(fpu_exception_out, dest_write_out));
        chk("valid", 32'h1, pk2(1'h0, result_valid_out));
        dp(1'h1, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h08);
        op1(OP_DIV, 32'h0);
        chk("zdiv_inf", 32'hff80_0000, result_out);
        rd(sr);
        chk("cause_z", 32'h0000_8060, sr);
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h00);
        op1(OP_SUB, 32'h0);
        rd(sr);
        chk("sticky", 32'h0000_0060, sr);
        op1(OP_LOAD_FPSC, 32'h0000_0800);
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h10);
        op1(OP_ADD, 32'h0);
        chk("trap_v", 32'h2, pk2(fpu_exception_out, dest_write_out));
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h00);
        op1(OP_XFORM, 32'h0);
        chk("trap_xf", 32'h2, pk2(fpu_exception_out, dest_write_out));
        op1(OP_LOAD_FPSC, 32'h0000_0200);
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h04);
        op1(OP_MUL, 32'h0);
        chk("trap_may_o", 32'h2, pk2(fpu_exception_out, dest_write_out));
        rd(sr);
        chk("empty_cause", 32'h0000_0200, sr);
        op1(OP_LOAD_FPSC, 32'h0);
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h20);
        op1(OP_MAC, 32'h0);
        chk("trap_e", 32'h2, pk2(fpu_exception_out, dest_write_out));
        dp(1'h0, 10'h07f, 24'h800000, 1'h0, 1'h0, 6'h00);
        op1(OP_INNER, 32'h0);
        rd(sr);
        chk("inner_i", 32'h0000_1004, sr);
        op1(OP_LOAD_FPSC, 32'h0000_0080);
        op1(OP_INNER, 32'h0);
        chk("trap_i", 32'h2, pk2(fpu_exception_out, dest_write_out));
    endtask : t_except

    // =====================================================================
    // run control
    task automatic stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial begin
        clock_in = 1'h0;
        forever #50 clock_in = ~clock_in;
    end

    initial begin
        sys_rst_in = 1'h1;
        clk_en_in = 1'h1;
        num_errors = 0;
        n_compared = 0;
        dp(1'h0, 10'h0, 24'h0, 1'h0, 1'h0, 6'h0);
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        sys_rst_in = 1'h0;
        t_regs;
        t_illegal;
        t_round;
        t_except;
        stop_test;
    end

    // about 140 cycles are needed; a hang is cut well past that
    initial begin
        #200_000;
        num_errors++;
        stop_test;
    end
endmodule : fpu_round_exception_ctrl_tb
`default_nettype wire
